// file: include/pin_crossbar_pkg.sv
// Purpose: shared constants and carriers for the priority pin crossbar
// Assumes: 32 crossbar pins, 30 peripheral signal slots in priority order
// Notes:   slot order below is the placement order of the decoder
package pin_crossbar_pkg;
    localparam int NPINS = 32;
    localparam int PIN_W = 5;
    localparam int NSLOT = 30;
    // ==========================================
    // slot indices, highest priority first
    localparam int S_U0TX = 0;
    localparam int S_U0RX = 1;
    localparam int S_CANTX = 2;
    localparam int S_CANRX = 3;
    localparam int S_SPI0 = 4;
    localparam int S_NSS = 7;
    localparam int S_SDA = 8;
    localparam int S_SCL = 9;
    localparam int S_CP0 = 10;
    localparam int S_SYSCK = 16;
    localparam int S_CEX0 = 17;
    localparam int N_CEX = 6;
    localparam int S_ECI = 23;
    localparam int S_T0 = 24;
    localparam int S_T1 = 25;
    localparam int S_U1 = 26;
    localparam int S_LIN = 28;
    // ==========================================
    // fixed pins
    localparam logic [PIN_W-1:0] PIN_U0TX = 5'h04;
    localparam logic [PIN_W-1:0] PIN_U0RX = 5'h05;
    localparam logic [PIN_W-1:0] PIN_CANTX = 5'h06;
    localparam logic [PIN_W-1:0] PIN_CANRX = 5'h07;
    // ==========================================
    // routing field positions
    localparam int R1_FIRST_UART = 0;
    localparam int R1_CAN = 1;
    localparam int R1_SPI = 2;
    localparam int R1_SMB = 3;
    localparam int R1_CP0 = 4;
    localparam int R2_SYSCK = 1;
    localparam int R2_PCA_LO = 2;
    localparam int R2_ECI = 5;
    localparam int R2_T0 = 6;
    localparam int R2_T1 = 7;
    localparam int R3_LIN = 0;
    localparam int R3_UART1 = 1;
    localparam int R3_CP2 = 2;
    localparam int R3_XBAR = 6;
    localparam int R3_PUD = 7;
    localparam logic [2:0] PCA_RESERVED = 3'h7;
    localparam logic [1:0] NSS_THREE_WIRE = 2'h0;
    // ==========================================
    // reset values
    localparam logic [7:0] ROUTE_RESET = 8'h00;
    localparam logic [NPINS-1:0] INPUT_MODE_RESET = 32'hFFFFFFFF;
    localparam logic [NPINS-1:0] PIN_ZERO = 32'h00000000;

    typedef struct packed {
        logic [7:0]       route_select_first;
        logic [7:0]       route_select_second;
        logic [7:0]       route_select_third;
        logic [1:0]       slave_select_mode;
        logic [NPINS-1:0] pin_skip_mask;
        logic [NPINS-1:0] pin_input_mode_select;
        logic [NPINS-1:0] pin_output_mode_select;
    } xbar_config_type;

    typedef struct packed {
        logic [NPINS-1:0] pad_out;
        logic [NPINS-1:0] pad_oe;
        logic [NPINS-1:0] pullup_en;
    } pad_drive_type;
endpackage

// file: rtl/pin_event_capture.sv
// Purpose: pad synchroniser and per-pin transition detector
// Assumes: pad levels are asynchronous to core_clk
// Notes:   edge is a one-cycle pulse, level is the synchronised pad
module pin_event_capture #(
    parameter int WIDTH = 32
) (
    input  wire logic             core_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pad_in,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] edge_pulse
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] prev;

    // ==========================================
    // two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        // idle pads sit at the pull-up level; starting there avoids a false edge after reset
        if (rst) begin
            meta  <= '1;
            level <= '1;
        end else begin
            meta  <= pad_in;
            level <= meta;
        end
    end

    // ==========================================
    // transition detect on the synchronised level
    always_ff @(posedge core_clk) begin
        if (rst) begin
            prev       <= '1;
            edge_pulse <= '0;
        end else begin
            prev       <= level;
            edge_pulse <= level ^ prev;
        end
    end
endmodule

// file: rtl/priority_pin_crossbar.sv
// Purpose: priority crossbar placing peripheral signals on port pins
// Assumes: config ports are quasi-static software settings on core_clk
// Notes:   map follows config by two cycles, pads by three
// Behaviour
// [RQ1] edge events raise interrupt or wake
// [RQ2] events on digital pins only, never analog
// [RQ3] each enabled resource takes lowest free pin
// [RQ4] assigned pins are passed over afterwards
// [RQ5] skipped pins count as already assigned
// [RQ6] first uart fixed on pins four, five
// [RQ7] can controller fixed on pins six, seven
// [RQ8] software skips pins used outside crossbar
// [RQ9] two-wire and uart/can/lin claim both pins
// [RQ10] leftover pins stay general purpose
// [RQ11] slave select routed only in four-wire mode
// [RQ12] software follows the documented init order
// [RQ13] input mode one digital, reset digital
// [RQ14] analog pin: no pullup, driver, receiver
// [RQ15] software picks output mode for every pin
// [RQ16] two-wire bus pins always open-drain
// [RQ17] pullups on open-drain unless globally disabled
// [RQ18] pullup off while driving low
// [RQ19] crossbar enable bit activates routing
// [RQ20] disabled crossbar: pins plain inputs
// [RQ21] disabled crossbar: all drivers off
// [RQ22] output mode one push-pull, zero open-drain
// [RQ23] analog reads zero, digital reads pad
// [RQ24] map recomputed whenever settings change
module priority_pin_crossbar
    import pin_crossbar_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire xbar_config_type      config_in,
    input  wire logic [NPINS-1:0]     gpio_out_latch,
    input  wire logic [NSLOT-1:0]     periph_out,
    input  wire logic [NSLOT-1:0]     periph_drive,
    input  wire logic [NPINS-1:0]     event_mask,
    input  wire logic                 low_power_mode,
    input  wire logic [NPINS-1:0]     pad_in,
    output pad_drive_type             pad,
    output logic      [NPINS-1:0]     pin_read,
    output logic      [NSLOT-1:0]     periph_in,
    output logic      [NSLOT-1:0]     slot_hit,
    output logic      [NPINS-1:0]     pin_event,
    output logic                      event_irq,
    output logic                      wake_request
);
    xbar_config_type  cfg;
    logic [NSLOT-1:0] en;
    logic [NSLOT-1:0] next_hit;
    logic [PIN_W-1:0] next_slot_pin [NSLOT];
    logic [PIN_W-1:0] slot_pin [NSLOT];
    logic [NPINS-1:0] taken;
    logic             found;
    logic [NPINS-1:0] owned;
    logic [NPINS-1:0] claimed;
    logic             dup_claim;
    logic [4:0]       owner [NPINS];
    logic [NPINS-1:0] digital;
    logic [NPINS-1:0] pushpull;
    logic             xbar;
    logic             pud;
    logic [2:0]       pca_sel;
    pad_drive_type    next_pad;
    logic [NPINS-1:0] sync_level;
    logic [NPINS-1:0] sync_edge;
    logic [NPINS-1:0] next_event;
    logic             val;
    logic             drv;
    logic             od;

    assign digital  = cfg.pin_input_mode_select;
    assign pushpull = cfg.pin_output_mode_select;
    assign xbar     = cfg.route_select_third[R3_XBAR];
    assign pud      = cfg.route_select_third[R3_PUD];
    assign pca_sel  = cfg.route_select_second[R2_PCA_LO +: 3];

    // ==========================================
    // configuration capture
    // [RQ13] reset leaves every pin digital
    // [RQ24] settings re-sampled every cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cfg                        <= '0;
            cfg.route_select_first     <= ROUTE_RESET;
            cfg.pin_input_mode_select  <= INPUT_MODE_RESET;
        end else begin
            cfg <= config_in;
        end
    end

    // ==========================================
    // slot enables
    always_comb begin
        en = '0;
        if (xbar) begin
            // [RQ19] enable bit gates every route
            // [RQ9] paired signals enabled together
            en[S_U0TX]  = cfg.route_select_first[R1_FIRST_UART];
            en[S_U0RX]  = cfg.route_select_first[R1_FIRST_UART];
            en[S_CANTX] = cfg.route_select_first[R1_CAN];
            en[S_CANRX] = cfg.route_select_first[R1_CAN];
            en[S_SPI0 +: 3] = {3{cfg.route_select_first[R1_SPI]}};
            // [RQ11] no slave select in three-wire mode
            en[S_NSS] = cfg.route_select_first[R1_SPI] && cfg.slave_select_mode != NSS_THREE_WIRE;
            en[S_SDA] = cfg.route_select_first[R1_SMB];
            en[S_SCL] = cfg.route_select_first[R1_SMB];
            en[S_CP0 +: 4] = cfg.route_select_first[R1_CP0 +: 4];
            en[S_CP0 + 4]  = cfg.route_select_third[R3_CP2];
            en[S_CP0 + 5]  = cfg.route_select_third[R3_CP2 + 1];
            en[S_SYSCK] = cfg.route_select_second[R2_SYSCK];
            for (int k = 0; k < N_CEX; k++) begin
                en[S_CEX0 + k] = pca_sel != PCA_RESERVED && int'(pca_sel) > k;
            end
            en[S_ECI]  = cfg.route_select_second[R2_ECI];
            en[S_T0]   = cfg.route_select_second[R2_T0];
            en[S_T1]   = cfg.route_select_second[R2_T1];
            en[S_U1]     = cfg.route_select_third[R3_UART1];
            en[S_U1 + 1] = cfg.route_select_third[R3_UART1];
            en[S_LIN]     = cfg.route_select_third[R3_LIN];
            en[S_LIN + 1] = cfg.route_select_third[R3_LIN];
        end
    end

    // ==========================================
    // priority decoder
    always_comb begin
        // [RQ5] skipped pins start out as taken
        taken    = cfg.pin_skip_mask;
        next_hit = '0;
        found    = 1'b0;
        for (int s = 0; s < NSLOT; s++) begin
            next_slot_pin[s] = '0;
        end
        // [RQ6] first uart on its fixed pins
        if (en[S_U0TX]) begin
            taken[PIN_U0TX] = 1'b1;
            taken[PIN_U0RX] = 1'b1;
            next_hit[S_U0TX] = 1'b1;
            next_hit[S_U0RX] = 1'b1;
            next_slot_pin[S_U0TX] = PIN_U0TX;
            next_slot_pin[S_U0RX] = PIN_U0RX;
        end
        // [RQ7] can controller on its fixed pins
        if (en[S_CANTX]) begin
            taken[PIN_CANTX] = 1'b1;
            taken[PIN_CANRX] = 1'b1;
            next_hit[S_CANTX] = 1'b1;
            next_hit[S_CANRX] = 1'b1;
            next_slot_pin[S_CANTX] = PIN_CANTX;
            next_slot_pin[S_CANRX] = PIN_CANRX;
        end
        // [RQ3] lowest free pin in priority order
        for (int s = S_SPI0; s < NSLOT; s++) begin
            found = 1'b0;
            for (int p = 0; p < NPINS; p++) begin
                if (en[s] && !found && !taken[p]) begin
                    found = 1'b1;
                    // [RQ4] a placed pin is no longer free
                    taken[p] = 1'b1;
                    next_hit[s] = 1'b1;
                    next_slot_pin[s] = PIN_W'(p);
                end
            end
        end
    end

    // [RQ24] map follows settings without an apply step
    always_ff @(posedge core_clk) begin
        if (rst) begin
            slot_hit <= '0;
            for (int s = 0; s < NSLOT; s++) begin
                slot_pin[s] <= '0;
            end
        end else begin
            slot_hit <= next_hit;
            for (int s = 0; s < NSLOT; s++) begin
                slot_pin[s] <= next_slot_pin[s];
            end
        end
    end

    // ==========================================
    // pin ownership from the registered map
    always_comb begin
        owned     = '0;
        claimed   = '0;
        dup_claim = 1'b0;
        for (int p = 0; p < NPINS; p++) begin
            owner[p] = '0;
        end
        for (int s = 0; s < NSLOT; s++) begin
            if (slot_hit[s]) begin
                dup_claim = dup_claim | owned[slot_pin[s]];
                owned[slot_pin[s]] = 1'b1;
                owner[slot_pin[s]] = 5'(s);
                if (s >= S_SPI0) begin
                    claimed[slot_pin[s]] = 1'b1;
                end
            end
        end
    end

    // ==========================================
    // pad drive, pull-up and open-drain control
    always_comb begin
        next_pad = '0;
        val      = 1'b1;
        drv      = 1'b0;
        od       = 1'b1;
        for (int p = 0; p < NPINS; p++) begin
            // [RQ10] unowned pins stay general purpose
            val = owned[p] ? periph_out[owner[p]] : gpio_out_latch[p];
            drv = owned[p] ? periph_drive[owner[p]] : 1'b1;
            // [RQ22] mode bit one is push-pull
            // [RQ16] two-wire bus pins forced open-drain
            od = !pushpull[p] || (owned[p] && (owner[p] == 5'(S_SDA) || owner[p] == 5'(S_SCL)));
            // [RQ20] [RQ21] no driver while routing is off
            // [RQ14] analog pins never driven
            if (xbar && digital[p] && drv) begin
                next_pad.pad_oe[p]  = od ? !val : 1'b1;
                next_pad.pad_out[p] = od ? 1'b0 : val;
            end
            // [RQ17] open-drain pull-ups unless globally off
            // [RQ18] no pull-up while pulling low
            next_pad.pullup_en[p] = digital[p] && !pud && (od || !xbar)
                                    && !(next_pad.pad_oe[p] && !next_pad.pad_out[p]);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            pad.pad_out   <= PIN_ZERO;
            pad.pad_oe    <= PIN_ZERO;
            pad.pullup_en <= INPUT_MODE_RESET;
        end else begin
            pad <= next_pad;
        end
    end

    // ==========================================
    // receive side
    pin_event_capture #(
        .WIDTH (NPINS)
    ) u_capture (
        .core_clk   (core_clk),
        .rst        (rst),
        .pad_in     (pad_in),
        .level      (sync_level),
        .edge_pulse (sync_edge)
    );

    // [RQ23] analog reads zero, digital reads the pad
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_read <= PIN_ZERO;
        end else begin
            pin_read <= sync_level & digital;
        end
    end

    // [RQ14] analog receiver gated; idle inputs see one
    always_ff @(posedge core_clk) begin
        if (rst) begin
            periph_in <= '1;
        end else begin
            for (int s = 0; s < NSLOT; s++) begin
                periph_in[s] <= slot_hit[s] ? (sync_level[slot_pin[s]] || !digital[slot_pin[s]]) : 1'b1;
            end
        end
    end

    // ==========================================
    // event capture, works with or without routing
    // [RQ2] analog pins raise no events
    assign next_event = sync_edge & digital & event_mask;

    // [RQ1] interrupt on any event, wake in low power
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_event    <= PIN_ZERO;
            event_irq    <= 1'b0;
            wake_request <= 1'b0;
        end else begin
            pin_event    <= next_event;
            event_irq    <= |next_event;
            wake_request <= |next_event && low_power_mode;
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    logic [PIN_W-1:0] sda_pin;
    assign sda_pin = slot_pin[S_SDA];

    sequence s_event_in_sleep;
        (|pin_event) && $past(low_power_mode);
    endsequence

    sequence s_three_wire_spi;
        xbar && cfg.route_select_first[R1_SPI] && cfg.slave_select_mode == NSS_THREE_WIRE;
    endsequence

    a_wake_on_event: assert property (s_event_in_sleep |-> wake_request && event_irq) // [RQ1]
        else $error("event in low power did not wake");
    a_event_analog: assert property (1'b1 |=> (pin_event & ~$past(digital)) == '0) // [RQ2]
        else $error("event reported on analog pin");
    a_pin_unique: assert property (!dup_claim) // [RQ4]
        else $error("pin given to two slots");
    a_skip_honoured: assert property (1'b1 |=> (claimed & $past(cfg.pin_skip_mask)) == '0) // [RQ5]
        else $error("skipped pin placed");
    a_uart_fixed: assert property (en[S_U0TX] |=> slot_hit[S_U0RX] && slot_pin[S_U0TX] == PIN_U0TX
                                   && slot_pin[S_U0RX] == PIN_U0RX) // [RQ6]
        else $error("first uart not on fixed pins");
    a_can_fixed: assert property (en[S_CANTX] |=> slot_hit[S_CANRX] && slot_pin[S_CANTX] == PIN_CANTX
                                  && slot_pin[S_CANRX] == PIN_CANRX) // [RQ7]
        else $error("can not on fixed pins");
    a_nss_three_wire: assert property (s_three_wire_spi |=> slot_hit[S_SPI0] && !slot_hit[S_NSS]) // [RQ11]
        else $error("slave select routed in three-wire mode");
    a_reset_digital: assert property ($fell(rst) |-> digital == INPUT_MODE_RESET) // [RQ13]
        else $error("pins not digital after reset");
    a_analog_quiet: assert property (1'b1 |=> ((pad.pad_oe | pad.pullup_en) & ~$past(digital)) == '0) // [RQ14]
        else $error("analog pin driven or pulled");
    a_sda_open_drain: assert property (slot_hit[S_SDA] && xbar |=> !pad.pad_out[$past(sda_pin)]) // [RQ16]
        else $error("two-wire data pin driven high");
    a_pullup_low: assert property ((pad.pad_oe & ~pad.pad_out & pad.pullup_en) == '0) // [RQ18]
        else $error("pull-up on while driving low");
    a_drivers_off: assert property (!xbar |=> pad.pad_oe == '0 ##1 (slot_hit == '0 || $past(xbar))) // [RQ21]
        else $error("driver on with crossbar disabled");
    a_read_analog: assert property (1'b1 |=> (pin_read & ~$past(digital)) == '0) // [RQ23]
        else $error("analog pin read back nonzero");
    a_map_idle: assert property (!xbar |=> slot_hit == '0) // [RQ20]
        else $error("slot placed with crossbar disabled");
    a_pullup_disabled: assert property (pud |=> pad.pullup_en == '0) // [RQ17]
        else $error("pull-up on while globally disabled");
    a_gpio_driven: assert property (1'b1 |=> (pad.pad_oe & $past(~owned & digital & pushpull & {NPINS{xbar}}))
                                    == $past(~owned & digital & pushpull & {NPINS{xbar}})) // [RQ10]
        else $error("general purpose push-pull pin not driven");
endmodule

// file: dv/pad_partner.sv
// Purpose: external circuitry on the port pads of the crossbar
// Assumes: the bench decides which pads are held from outside
// Notes:   a pad nobody drives or pulls wanders every cycle
module pad_partner
    import pin_crossbar_pkg::*;
(
    input  wire logic             core_clk,
    input  wire pad_drive_type    pad,
    input  wire logic [NPINS-1:0] ext_en,
    input  wire logic [NPINS-1:0] ext_val,
    output logic      [NPINS-1:0] pad_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [NPINS-1:0] wander;

    // ==========================
    // pad level
    initial wander = '0;
    // floating pads must not settle to a value the simulator picks
    always @(posedge core_clk) begin
        wander <= ~wander;
    end

    // device wins on contention so bench levels stay predictable
    always_comb begin
        for (int i = 0; i < NPINS; i++) begin
            if (pad.pad_oe[i]) pad_in[i] = pad.pad_out[i];
            else if (ext_en[i]) pad_in[i] = ext_val[i];
            else if (pad.pullup_en[i]) pad_in[i] = 1'b1;
            else pad_in[i] = wander[i];
        end
    end
endmodule

// file: dv/priority_pin_crossbar_tb.sv
// Purpose: self-checking bench for the priority pin crossbar
// Assumes: outputs settle within eight clocks of a setting change
// Notes:   expected drive is rebuilt from routing settings at each check
module priority_pin_crossbar_tb import pin_crossbar_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================
    // signals
    logic             core_clk = 1'b0;
    logic             rst = 1'b1;
    logic             lpm = 1'b0;
    xbar_config_type  cfg;
    logic [NPINS-1:0] gpio_latch, ev_mask = '0, ext_en, ext_val, pad_in, pin_read, pin_event;
    logic [NSLOT-1:0] p_out, p_drive, periph_in, slot_hit;
    logic             event_irq, wake_request;
    pad_drive_type    pad;
    logic [NPINS-1:0] e_oe, e_out, e_pu, e_rd, k_rd, lvl, ev_seen;
    logic [NSLOT-1:0] e_hit, e_pin, k_pin;
    int               miscompares = 0, n_compared = 0, irq_cnt = 0, wake_cnt = 0;

    always #12.5 core_clk = ~core_clk;

    priority_pin_crossbar DUT (
        .core_clk(core_clk), .rst(rst), .config_in(cfg), .gpio_out_latch(gpio_latch),
        .periph_out(p_out), .periph_drive(p_drive), .event_mask(ev_mask),
        .low_power_mode(lpm), .pad_in(pad_in), .pad(pad), .pin_read(pin_read),
        .periph_in(periph_in), .slot_hit(slot_hit), .pin_event(pin_event),
        .event_irq(event_irq), .wake_request(wake_request)
    );
    pad_partner ext (.core_clk(core_clk), .pad(pad), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    always @(posedge core_clk) begin
        if (event_irq === 1'b1) irq_cnt++;
        if (wake_request === 1'b1) wake_cnt++;
        ev_seen = ev_seen | pin_event;
    end

    // ==========================
    // checking
    task automatic check_vec(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic predict();
        logic [7:0]       r1, r2, r3;
        logic [NSLOT-1:0] en;
        logic [NPINS-1:0] taken;
        int               own [NPINS];
        int               at [NSLOT];
        int               p, n;
        logic             v, d, od, on, dig;
        r1 = cfg.route_select_first;
        r2 = cfg.route_select_second;
        r3 = cfg.route_select_third;
        on = r3[R3_XBAR];
        n = int'(r2[R2_PCA_LO+:3]);
        en[S_U0TX+:2] = {2{r1[R1_FIRST_UART]}};
        en[S_CANTX+:2] = {2{r1[R1_CAN]}};
        en[S_SPI0+:3] = {3{r1[R1_SPI]}};
        // slave select only in four-wire mode
        en[S_NSS] = r1[R1_SPI] && cfg.slave_select_mode != NSS_THREE_WIRE;
        en[S_SDA+:2] = {2{r1[R1_SMB]}};
        en[S_CP0+:4] = r1[R1_CP0+:4];
        en[S_CP0+4+:2] = r3[R3_CP2+:2];
        en[S_SYSCK] = r2[R2_SYSCK];
        for (int k = 0; k < N_CEX; k++) en[S_CEX0+k] = r2[R2_PCA_LO+:3] != PCA_RESERVED && k < n;
        en[S_ECI+:3] = r2[R2_ECI+:3];
        en[S_U1+:2] = {2{r3[R3_UART1]}};
        en[S_LIN+:2] = {2{r3[R3_LIN]}};
        taken = cfg.pin_skip_mask;
        for (int i = 0; i < NPINS; i++) own[i] = -1;
        for (int s = 0; s < NSLOT; s++) begin
            at[s] = -1;
            if (on && en[s]) begin
                // fixed pins, then lowest free pin
                p = s < S_SPI0 ? int'(PIN_U0TX) + s : 0;
                while (s >= S_SPI0 && p < NPINS && taken[p]) p++;
                if (p < NPINS) begin
                    at[s] = p;
                    own[p] = s;
                    taken[p] = 1'b1;
                end
            end
        end
        for (int i = 0; i < NPINS; i++) begin
            dig = cfg.pin_input_mode_select[i];
            v = own[i] < 0 ? gpio_latch[i] : p_out[own[i]];
            d = own[i] < 0 ? 1'b1 : p_drive[own[i]];
            od = !cfg.pin_output_mode_select[i] || own[i] == S_SDA || own[i] == S_SCL;
            // analog pins: no driver, pull-up or receiver
            e_oe[i] = on && dig && d && !(od && v);
            e_out[i] = e_oe[i] && !od && v;
            e_pu[i] = dig && !r3[R3_PUD] && (od || !on) && !(e_oe[i] && !e_out[i]);
            lvl[i] = e_oe[i] ? e_out[i] : ext_en[i] ? ext_val[i] : 1'b1;
            k_rd[i] = !dig || e_oe[i] || ext_en[i] || e_pu[i];
            e_rd[i] = dig && lvl[i];
        end
        for (int s = 0; s < NSLOT; s++) begin
            e_hit[s] = at[s] >= 0;
            e_pin[s] = !e_hit[s] || !cfg.pin_input_mode_select[at[s]] || lvl[at[s]];
            k_pin[s] = !e_hit[s] || k_rd[at[s]];
        end
    endtask

    task automatic check_all();
        predict();
        check_vec("pad_oe", e_oe, pad.pad_oe);
        check_vec("pad_out", e_out, pad.pad_out & e_oe);
        check_vec("pullup_en", e_pu, pad.pullup_en);
        check_vec("slot_hit", 32'(e_hit), 32'(slot_hit));
        check_vec("pin_read", e_rd & k_rd, pin_read & k_rd);
        check_vec("periph_in", 32'(e_pin & k_pin), 32'(periph_in & k_pin));
    endtask

    task automatic check_reset();
        check_vec("reset pad_oe", '0, pad.pad_oe);
        check_vec("reset pullup_en", '1, pad.pullup_en);
        check_vec("reset pin_read", '0, pin_read);
        check_vec("reset slot_hit", '0, 32'(slot_hit));
        check_vec("reset periph_in", 32'h3FFFFFFF, 32'(periph_in));
    endtask

    // ==========================
    // stimulus
    task automatic put(xbar_config_type t);
        @(posedge core_clk);
        cfg <= t;
    endtask

    // software init order; no separate apply step
    task automatic apply(xbar_config_type c);
        xbar_config_type t;
        t = cfg;
        t.pin_input_mode_select = c.pin_input_mode_select;
        put(t);
        p_out <= {p_out[0], p_out[NSLOT-1:1]};
        gpio_latch <= ~gpio_latch;
        t.pin_output_mode_select = c.pin_output_mode_select;
        put(t);
        t.pin_skip_mask = c.pin_skip_mask;
        put(t);
        t = c;
        t.route_select_third[R3_XBAR] = 1'b0;
        put(t);
        put(c);
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check_all();
    endtask

    task automatic toggle(int pin, int n_irq, int n_wake);
        @(posedge core_clk);
        ext_val[pin] <= !ext_val[pin];
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check_vec("event_irq count", n_irq, irq_cnt);
        check_vec("wake_request count", n_wake, wake_cnt);
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        cfg = '0;
        cfg.pin_input_mode_select = INPUT_MODE_RESET;
        p_out = 30'h15A53C69;
        p_drive = 30'h3EFFFFD5;
        gpio_latch = 32'hA5C30F96;
        ext_en = 32'h0000FF08;
        ext_val = 32'h00005A00;
        repeat (3) @(posedge core_clk);
        @(negedge core_clk);
        check_reset();
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check_all();
        apply('{8'h0F, 8'h00, 8'h00, 2'h0, 32'h0000000B, '1, '1});
        apply('{8'h0F, 8'h00, 8'h41, 2'h0, 32'h0000000B, '1, '1});
        apply('{8'hFF, 8'hFA, 8'h4F, 2'h1, 32'h0, '1, '0});
        apply('{8'h07, 8'h04, 8'h40, 2'h2, 32'h00000070, '1, 32'hFFFF0000});
        apply('{8'h03, 8'h1C, 8'hC0, 2'h0, 32'h0000F000, 32'hFFFF0FFF, 32'h00FF00FF});
        apply('{8'h00, 8'h00, 8'h00, 2'h0, 32'h0, 32'hFFFFFFF7, '1});
        @(posedge core_clk);
        ev_mask <= 32'h00000208;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        irq_cnt = 0;
        wake_cnt = 0;
        ev_seen = '0;
        toggle(9, 1, 0);
        toggle(3, 1, 0);
        @(posedge core_clk);
        lpm <= 1'b1;
        toggle(9, 2, 1);
        check_vec("pin_event seen", 32'h00000200, ev_seen);
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check_reset();
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        @(negedge core_clk);
        check_all();
        check_vec("event_irq after reset", 2, irq_cnt);
        report_and_stop();
    end
endmodule
